// >>> design/mfp_cfg.svh
// Configuration constants for the multimode flyback PWM control core.
`ifndef MFP_CFG_SVH
`define MFP_CFG_SVH
`define MFP_CLK_KHZ 100000
`define MFP_CLK_NS 10
`define MFP_CENTER_KHZ 65
`define MFP_FLOOR_KHZ 22
`define MFP_DUTY_NUM 4
`define MFP_DUTY_DEN 5
`define MFP_DITH_DEPTH_PCT 6
`define MFP_DITH_PERIOD_US 2500
`define MFP_SS_TIME_US 2500
`define MFP_SS_START_MV 50
`define MFP_SS_FULL_MV 500
`define MFP_OVP_CYCLES 10
`define MFP_OTP_CYCLES 50
`define MFP_LEB_NS 300
`define MFP_HOLD_ON_NS 1000
`define MFP_QR_WAIT_NS 2000
`define MFP_RED_REF_CODE 128
`define MFP_RED_SLOPE 24
`endif

// >>> design/mfp_core.sv
// Multimode flyback PWM control core: oscillator, modes, blanking, faults.
//
// Overview of operation
// - Centre switching frequency 65 kHz in PWM.
// - Dither frequency six percent, 2.5 ms sweep.
// - On-time never exceeds eighty percent of period.
// - Peak limit ramps 50 mV to full, 2.5 ms.
// - Soft start repeats on every restart.
// - Low feedback lowers frequency linearly with load.
// - Below end reference frequency holds 22 kHz.
// - Burst low reference stops switching unless in holdup.
// - Switching resumes at burst high reference.
// - Supply at 9 V forces holdup switching.
// - Reduced and burst modes start at valley.
// - Current limit ignored during leading-edge blanking.
// - Pulse ends when current reaches feedback level.
// - Ten high-current cycles trip over-voltage fault.
// - Fifty low-voltage cycles trip over-temperature fault.
// - Gate pulled low during supply lockout.
// - All protections recover without latching.
`include "mfp_cfg.svh"

module mfp_core #(
	parameter int PER_FLOOR = `MFP_CLK_KHZ / `MFP_FLOOR_KHZ,
	parameter int SS_TIME_CYC = `MFP_SS_TIME_US * 1000 / `MFP_CLK_NS
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input mfp_pkg::mfp_cmp_s cmp_i,
	output logic gate_drive_out_o,
	output logic gate_pull_low_o,
	output logic [9:0] soft_limit_mv_o,
	output mfp_pkg::mfp_stat_s stat_o
);
	localparam int PER_CENTER = `MFP_CLK_KHZ / `MFP_CENTER_KHZ;
	localparam int DITH_DEV = PER_CENTER * `MFP_DITH_DEPTH_PCT / 200;
	localparam int DITH_STEP_CYC = `MFP_DITH_PERIOD_US * 1000
		/ `MFP_CLK_NS / (4 * DITH_DEV);
	localparam int LEB_CYC = (`MFP_LEB_NS + `MFP_CLK_NS - 1) / `MFP_CLK_NS;
	localparam int HOLD_ON_CYC = `MFP_HOLD_ON_NS / `MFP_CLK_NS;
	localparam int QR_WAIT_CYC = `MFP_QR_WAIT_NS / `MFP_CLK_NS;
	localparam int SS_SPAN = `MFP_SS_FULL_MV - `MFP_SS_START_MV;
	localparam int SS_STEP_RAW = SS_TIME_CYC / SS_SPAN;
	localparam int SS_STEP_CYC = (SS_STEP_RAW < 1) ? 1 : SS_STEP_RAW;

	// Largest on-time in cycles that keeps the duty at or under the ceiling.
	function automatic logic [12:0] duty_max(input logic [12:0] per);
		duty_max = 13'((32'(per) * `MFP_DUTY_NUM) / `MFP_DUTY_DEN);
	endfunction : duty_max

	mfp_pkg::mfp_state_e st_q, st_d;
	mfp_pkg::mfp_mode_e mode_q, mode_d;
	logic [12:0] cnt_q, cnt_d, per_q, per_d, dmax_q, dmax_d, on_q, on_d;
	logic gate_q, gate_d, pull_q, pull_d;
	logic burst_q, burst_d, hold_q, hold_d;
	logic [5:0] ovp_cnt_q, ovp_cnt_d, otp_cnt_q, otp_cnt_d;
	logic ovp_q, ovp_d, otp_q, otp_d;
	logic [6:0] dith_q, dith_d;
	logic dith_up_q, dith_up_d;
	logic [10:0] ddiv_q, ddiv_d;
	logic [9:0] ss_q, ss_d;
	logic [17:0] sdiv_q, sdiv_d;
	logic tick, qr, sw_en, gate_end;
	int p;

	// Mode selection; holdup overrides burst, burst overrides reduction.
	always_comb begin
		burst_d = burst_q;
		if (cmp_i.fb_at_burst_low) begin
			burst_d = 1'b1;
		end else if (cmp_i.fb_at_burst_high) begin
			burst_d = 1'b0;
		end
		hold_d = hold_q;
		if (cmp_i.supply_at_holdup) begin
			hold_d = 1'b1;
		end else if (cmp_i.supply_above_holdup) begin
			hold_d = 1'b0;
		end
		if (hold_q) begin
			mode_d = mfp_pkg::MFP_MODE_HOLDUP;
		end else if (burst_q) begin
			mode_d = mfp_pkg::MFP_MODE_BURST;
		end else if (cmp_i.fb_below_reduce_ref) begin
			mode_d = mfp_pkg::MFP_MODE_REDUCE;
		end else begin
			mode_d = mfp_pkg::MFP_MODE_PWM;
		end
	end

	// Valley switching applies in reduced and burst modes; a timeout keeps
	// the cycle going when ringing is too weak to show a valley.
	assign qr = (mode_q == mfp_pkg::MFP_MODE_REDUCE)
		|| (mode_q == mfp_pkg::MFP_MODE_BURST);
	assign tick = (cnt_q >= per_q - 13'h1) && (!qr || cmp_i.drain_valley
		|| (cnt_q >= per_q + 13'(QR_WAIT_CYC)));
	assign sw_en = !burst_q || hold_q;

	// Pulse termination: blanking hides the current comparators.
	assign gate_end = (on_q >= dmax_q - 13'h1)
		|| (hold_q && on_q >= 13'(HOLD_ON_CYC - 1))
		|| (on_q >= 13'(LEB_CYC)
		&& (cmp_i.cs_at_feedback || cmp_i.cs_at_soft_limit));

	// Dither triangle, stepped by a slow enable from its own divider.
	always_comb begin
		ddiv_d = ddiv_q + 11'h1;
		dith_d = dith_q;
		dith_up_d = dith_up_q;
		if (ddiv_q >= 11'(DITH_STEP_CYC - 1)) begin
			ddiv_d = 11'h0;
			if (dith_up_q) begin
				dith_d = dith_q + 7'h1;
				dith_up_d = ($signed(dith_q) < $signed(7'(DITH_DEV - 1)));
			end else begin
				dith_d = dith_q - 7'h1;
				dith_up_d = ($signed(dith_q) <= $signed(-7'(DITH_DEV - 1)));
			end
		end
	end

	// Next period, chosen at each cycle start from the current mode.
	always_comb begin
		p = PER_CENTER + int'($signed(dith_q));
		if (mode_q == mfp_pkg::MFP_MODE_HOLDUP) begin
			p = PER_FLOOR;
		end else if (mode_q != mfp_pkg::MFP_MODE_PWM) begin
			if (cmp_i.fb_below_freq_reduce_end_ref) begin
				p = PER_FLOOR;
			end else begin
				p = PER_CENTER + `MFP_RED_SLOPE
					* (`MFP_RED_REF_CODE - int'(cmp_i.feedback_in));
				if (p > PER_FLOOR) begin
					p = PER_FLOOR;
				end
				if (p < PER_CENTER) begin
					p = PER_CENTER;
				end
			end
		end
	end

	// Oscillator, gate, fault debounce and soft start.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q + 13'h1;
		per_d = per_q;
		dmax_d = dmax_q;
		ovp_cnt_d = ovp_cnt_q;
		otp_cnt_d = otp_cnt_q;
		ovp_d = ovp_q;
		otp_d = otp_q;
		pull_d = 1'b0;
		if (tick) begin
			cnt_d = 13'h0;
			per_d = 13'(p);
			dmax_d = duty_max(13'(p));
			ovp_cnt_d = cmp_i.fault_detect_in_high_current
				? ovp_cnt_q + 6'h1 : 6'h0;
			otp_cnt_d = cmp_i.fault_detect_in_low_voltage
				? otp_cnt_q + 6'h1 : 6'h0;
		end
		unique case (st_q)
			mfp_pkg::MFP_ST_RUN: begin
				if (tick && cmp_i.fault_detect_in_high_current
					&& ovp_cnt_q >= 6'(`MFP_OVP_CYCLES - 1)) begin
					st_d = mfp_pkg::MFP_ST_FAULT;
					ovp_d = 1'b1;
				end
				if (tick && cmp_i.fault_detect_in_low_voltage
					&& otp_cnt_q >= 6'(`MFP_OTP_CYCLES - 1)) begin
					st_d = mfp_pkg::MFP_ST_FAULT;
					otp_d = 1'b1;
				end
			end
			mfp_pkg::MFP_ST_FAULT: begin
				// Freeze the counts; no latch holds the fault.
				ovp_cnt_d = ovp_cnt_q;
				otp_cnt_d = otp_cnt_q;
				if (!cmp_i.fault_detect_in_high_current
					&& !cmp_i.fault_detect_in_low_voltage) begin
					st_d = mfp_pkg::MFP_ST_RUN;
					ovp_d = 1'b0;
					otp_d = 1'b0;
					ovp_cnt_d = 6'h0;
					otp_cnt_d = 6'h0;
				end
			end
		endcase
		on_d = gate_q ? on_q + 13'h1 : 13'h0;
		if (st_d == mfp_pkg::MFP_ST_FAULT) begin
			gate_d = 1'b0;
		end else if (gate_q) begin
			gate_d = !gate_end;
		end else begin
			gate_d = tick && sw_en && st_q == mfp_pkg::MFP_ST_RUN;
		end
		sdiv_d = sdiv_q + 18'h1;
		ss_d = ss_q;
		if (st_q == mfp_pkg::MFP_ST_FAULT) begin
			// Hold the ramp at its start so a restart ramps again.
			sdiv_d = 18'h0;
			ss_d = 10'(`MFP_SS_START_MV);
		end else if (sdiv_q >= 18'(SS_STEP_CYC - 1)) begin
			sdiv_d = 18'h0;
			if (ss_q < 10'(`MFP_SS_FULL_MV)) begin
				ss_d = ss_q + 10'h1;
			end
		end
	end

	// Registers; reset is supply lockout, so the gate is held low there.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_q <= mfp_pkg::MFP_ST_RUN;
			mode_q <= mfp_pkg::MFP_MODE_PWM;
			cnt_q <= 13'h0;
			per_q <= 13'(PER_CENTER);
			dmax_q <= duty_max(13'(PER_CENTER));
			on_q <= 13'h0;
			gate_q <= 1'b0;
			pull_q <= 1'b1;
			burst_q <= 1'b0;
			hold_q <= 1'b0;
			ovp_cnt_q <= 6'h0;
			otp_cnt_q <= 6'h0;
			ovp_q <= 1'b0;
			otp_q <= 1'b0;
			dith_q <= 7'h0;
			dith_up_q <= 1'b1;
			ddiv_q <= 11'h0;
			ss_q <= 10'(`MFP_SS_START_MV);
			sdiv_q <= 18'h0;
		end else begin
			st_q <= st_d;
			mode_q <= mode_d;
			cnt_q <= cnt_d;
			per_q <= per_d;
			dmax_q <= dmax_d;
			on_q <= on_d;
			gate_q <= gate_d;
			pull_q <= pull_d;
			burst_q <= burst_d;
			hold_q <= hold_d;
			ovp_cnt_q <= ovp_cnt_d;
			otp_cnt_q <= otp_cnt_d;
			ovp_q <= ovp_d;
			otp_q <= otp_d;
			dith_q <= dith_d;
			dith_up_q <= dith_up_d;
			ddiv_q <= ddiv_d;
			ss_q <= ss_d;
			sdiv_q <= sdiv_d;
		end
	end

	assign gate_drive_out_o = gate_q;
	assign gate_pull_low_o = pull_q;
	assign soft_limit_mv_o = ss_q;
	assign stat_o = '{mode: mode_q, over_voltage_fault: ovp_q,
		over_temp_fault: otp_q};

	// Checks on the generated waveform and the protection sequencing.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	a_duty_ceiling: assert property (gate_q |-> on_q < dmax_q)
		else $error("on-time passed the duty ceiling");
	a_leb_hold: assert property (gate_q && on_q < 13'(LEB_CYC - 1)
		&& dmax_q > 13'(LEB_CYC) && !hold_q |=> gate_q)
		else $error("pulse ended inside blanking");
	a_cs_end: assert property (gate_q && on_q >= 13'(LEB_CYC)
		&& cmp_i.cs_at_feedback |=> !gate_q)
		else $error("current limit did not end the pulse");
	a_burst_stop: assert property (burst_q && !hold_q && !gate_q
		|=> !gate_q)
		else $error("switching during burst stop");
	a_ovp_trip: assert property (st_q == mfp_pkg::MFP_ST_RUN && tick
		&& cmp_i.fault_detect_in_high_current
		&& ovp_cnt_q == 6'(`MFP_OVP_CYCLES - 1)
		|=> st_q == mfp_pkg::MFP_ST_FAULT && ovp_q)
		else $error("over-voltage fault missed");
	a_otp_trip: assert property (st_q == mfp_pkg::MFP_ST_RUN && tick
		&& cmp_i.fault_detect_in_low_voltage
		&& otp_cnt_q == 6'(`MFP_OTP_CYCLES - 1)
		|=> st_q == mfp_pkg::MFP_ST_FAULT && otp_q)
		else $error("over-temperature fault missed");
	a_fault_quiet: assert property (st_q == mfp_pkg::MFP_ST_FAULT
		|-> !gate_q)
		else $error("gate active during fault");
	a_ss_restart: assert property (st_q == mfp_pkg::MFP_ST_FAULT
		|=> ss_q == 10'(`MFP_SS_START_MV))
		else $error("soft start not rearmed");
	a_floor_hold: assert property (tick && mode_q != mfp_pkg::MFP_MODE_PWM
		&& cmp_i.fb_below_freq_reduce_end_ref
		|=> per_q == 13'(PER_FLOOR))
		else $error("frequency floor not held");
	a_centre_period: assert property (tick
		&& mode_q == mfp_pkg::MFP_MODE_PWM
		|=> per_q <= 13'(PER_CENTER + DITH_DEV)
		&& per_q >= 13'(PER_CENTER - DITH_DEV))
		else $error("pwm period outside dither band");
	a_uvlo_low: assert property (@(posedge clk_i) disable iff (1'b0)
		srst_i |=> !gate_drive_out_o && gate_pull_low_o)
		else $error("gate not held low in lockout");

	c_fault_entry: cover property (st_q == mfp_pkg::MFP_ST_FAULT);
	c_burst: cover property (mode_q == mfp_pkg::MFP_MODE_BURST);
	c_holdup_pulse: cover property (hold_q && gate_q);
	c_reduce: cover property (mode_q == mfp_pkg::MFP_MODE_REDUCE && gate_q);
endmodule : mfp_core

// >>> design/mfp_pkg.sv
// Types shared by the multimode flyback PWM control core.
package mfp_pkg;
	typedef enum logic [1:0] {
		MFP_MODE_PWM,
		MFP_MODE_REDUCE,
		MFP_MODE_BURST,
		MFP_MODE_HOLDUP
	} mfp_mode_e;

	typedef enum logic {
		MFP_ST_RUN,
		MFP_ST_FAULT
	} mfp_state_e;

	// Comparator decisions coming from the analog front ends.
	typedef struct packed {
		logic [7:0] feedback_in;
		logic fb_below_reduce_ref;
		logic fb_below_freq_reduce_end_ref;
		logic fb_at_burst_low;
		logic fb_at_burst_high;
		logic supply_at_holdup;
		logic supply_above_holdup;
		logic cs_at_feedback;
		logic cs_at_soft_limit;
		logic drain_valley;
		logic fault_detect_in_high_current;
		logic fault_detect_in_low_voltage;
	} mfp_cmp_s;

	// Operating status reported alongside the gate drive.
	typedef struct packed {
		mfp_mode_e mode;
		logic over_voltage_fault;
		logic over_temp_fault;
	} mfp_stat_s;
endpackage : mfp_pkg

// >>> test/mfp_core_tb.sv
// Self-checking testbench of the multimode flyback PWM control core.
module mfp_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FLOOR = 3000;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	mfp_pkg::mfp_cmp_s drv = '0;
	mfp_pkg::mfp_cmp_s cmp_i;
	logic gate;
	logic pull_low;
	logic [9:0] soft_mv;
	mfp_pkg::mfp_stat_s stat;
	logic [15:0] fb_cyc = 16'hffff;
	logic [15:0] mv_step = 16'h0000;
	logic cs_fb;
	logic cs_soft;
	logic valley;
	int num_errors = 0;
	int cmp_count = 0;
	int hi;
	int per;
	mfp_pkg::mfp_cmp_s drv_otp = '0;
	logic gate_otp;
	logic [9:0] soft_otp;
	mfp_pkg::mfp_stat_s stat_otp;
	int cyc_now = 0;
	int rel_at = 0;
	int otp_at = 0;
	// Free-running 100 MHz clock.
	initial forever #5 clk_i = ~clk_i;
	// The switch model owns the sense and valley comparator bits.
	always_comb begin
		cmp_i = drv;
		cmp_i.cs_at_feedback = cs_fb;
		cmp_i.cs_at_soft_limit = cs_soft;
		cmp_i.drain_valley = valley;
	end
	mfp_core #(.PER_FLOOR(FLOOR), .SS_TIME_CYC(4500)) i_dut (
		.clk_i(clk_i), .srst_i(srst_i), .cmp_i(cmp_i),
		.gate_drive_out_o(gate), .gate_pull_low_o(pull_low),
		.soft_limit_mv_o(soft_mv), .stat_o(stat));
	mfp_sense_model i_sw (.clk_i(clk_i), .gate_i(gate),
		.soft_mv_i(soft_mv), .fb_cyc_i(fb_cyc), .mv_step_i(mv_step),
		.cs_fb_o(cs_fb), .cs_soft_o(cs_soft), .valley_o(valley));
	// A second core sees a cold detect pin from reset release on, so its
	// fifty-cycle debounce runs alongside the other scenarios and t_otp
	// only waits out the last few periods of it.
	mfp_core #(.PER_FLOOR(FLOOR), .SS_TIME_CYC(4500)) i_dut_otp (
		.clk_i(clk_i), .srst_i(srst_i), .cmp_i(drv_otp),
		.gate_drive_out_o(gate_otp), .gate_pull_low_o(),
		.soft_limit_mv_o(soft_otp), .stat_o(stat_otp));

	// Falling-edge cycle count; notes when the second core first trips.
	always @(negedge clk_i) begin
		cyc_now <= cyc_now + 1;
		if (otp_at == 0 && stat_otp.over_temp_fault === 1'b1) begin
			otp_at <= cyc_now;
		end
	end

	task automatic give_verdict;
		$display("Comparisons %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	// Range compare; the value is 4-state so an unknown never matches.
	task automatic chk(string what, int lo, int hi_l, logic [31:0] got);
		cmp_count++;
		if (!(got >= lo && got <= hi_l) || $isunknown(got)) begin
			num_errors++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi_l, got);
		end
	endtask : chk

	task automatic cyc(int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc

	// Bounded wait for the gate level; a hang ends the run.
	task automatic wait_gate(logic v, output int n);
		n = 0;
		while (gate !== v) begin
			@(negedge clk_i);
			n++;
			if (n > 20000) begin
				num_errors++;
				$display("Error gate wait expected %0d seen timeout", v);
				give_verdict();
			end
		end
	endtask : wait_gate

	// One whole switching period from rising edge to rising edge.
	task automatic measure(output int h, output int p);
		int n;
		int lo;
		wait_gate(1'b0, n);
		wait_gate(1'b1, n);
		wait_gate(1'b0, h);
		wait_gate(1'b1, lo);
		p = h + lo;
	endtask : measure

	task automatic t_reset;
		srst_i = 1'b1;
		cyc(6);
		chk("pull_low", 1, 1, pull_low);
		chk("gate", 0, 0, gate);
		chk("soft", 50, 50, soft_mv);
		chk("mode", 0, 0, stat);
		srst_i = 1'b0;
		rel_at = cyc_now;
		drv_otp.fault_detect_in_low_voltage = 1'b1;
		cyc(2);
		chk("pull_low", 0, 0, pull_low);
	endtask : t_reset

	task automatic t_soft;
		cyc(2000);
		chk("soft mid", 51, 499, soft_mv);
		cyc(2700);
		chk("soft end", 500, 500, soft_mv);
	endtask : t_soft

	task automatic t_pwm;
		measure(hi, per);
		chk("period", 1490, 1586, per);
		chk("duty", 1, per * 4 / 5, hi);
	endtask : t_pwm

	task automatic t_cs;
		fb_cyc = 16'h000a;
		measure(hi, per);
		chk("blank on", 30, 33, hi);
		fb_cyc = 16'h0064;
		measure(hi, per);
		chk("cs on", 100, 103, hi);
		fb_cyc = 16'hffff;
		mv_step = 16'h0002;
		measure(hi, per);
		chk("soft on", 249, 253, hi);
		mv_step = 16'h0000;
	endtask : t_cs

	task automatic t_ovp;
		int n;
		drv.fault_detect_in_high_current = 1'b1;
		n = 0;
		while (stat.over_voltage_fault !== 1'b1 && n < 20000) begin
			cyc(1);
			n++;
		end
		chk("ovp delay", 9 * 1492, 10 * 1586, n);
		if (n >= 20000) begin
			give_verdict();
		end
		n = 0;
		repeat (3000) begin
			cyc(1);
			n += (gate !== 1'b0) ? 1 : 0;
		end
		chk("ovp gate", 0, 0, n);
		chk("ovp soft", 50, 50, soft_mv);
		drv.fault_detect_in_high_current = 1'b0;
		cyc(3);
		chk("ovp clear", 0, 0, stat.over_voltage_fault);
		cyc(200);
		chk("restart soft", 51, 80, soft_mv);
		cyc(4600);
	endtask : t_ovp

	task automatic t_burst;
		int n;
		drv.fb_at_burst_low = 1'b1;
		cyc(2000);
		chk("burst mode", 2, 2, stat.mode);
		n = 0;
		repeat (4000) begin
			cyc(1);
			n += (gate !== 1'b0) ? 1 : 0;
		end
		chk("burst gate", 0, 0, n);
		drv.supply_at_holdup = 1'b1;
		measure(hi, per);
		chk("holdup mode", 3, 3, stat.mode);
		chk("holdup on", 99, 102, hi);
		drv.supply_at_holdup = 1'b0;
		drv.supply_above_holdup = 1'b1;
		drv.fb_at_burst_low = 1'b0;
		drv.fb_at_burst_high = 1'b1;
		measure(hi, per);
		chk("resume on", 1000, 1300, hi);
		drv.supply_above_holdup = 1'b0;
		drv.fb_at_burst_high = 1'b0;
	endtask : t_burst

	task automatic t_reduce;
		drv.fb_below_reduce_ref = 1'b1;
		drv.feedback_in = 8'h70;
		measure(hi, per);
		measure(hi, per);
		chk("reduce mode", 1, 1, stat.mode);
		chk("reduce per", 1600, FLOOR + 45, per);
		drv.fb_below_freq_reduce_end_ref = 1'b1;
		measure(hi, per);
		measure(hi, per);
		chk("floor per", FLOOR - 1, FLOOR + 45, per);
	endtask : t_reduce

	// The second core must trip on the fiftieth cold cycle and recover.
	task automatic t_otp;
		int n;
		n = 0;
		while (otp_at == 0 && n < 25000) begin
			cyc(1);
			n++;
		end
		chk("otp delay", 49 * 1492, 50 * 1586, otp_at - rel_at);
		if (otp_at == 0) begin
			give_verdict();
		end
		chk("otp flag", 1, 1, stat_otp.over_temp_fault);
		chk("otp ovp flag", 0, 0, stat_otp.over_voltage_fault);
		n = 0;
		repeat (1600) begin
			cyc(1);
			n += (gate_otp !== 1'b0) ? 1 : 0;
		end
		chk("otp gate", 0, 0, n);
		chk("otp soft", 50, 50, soft_otp);
		drv_otp.fault_detect_in_low_voltage = 1'b0;
		cyc(3);
		chk("otp clear", 0, 0, stat_otp.over_temp_fault);
	endtask : t_otp

	// Main sequence; stimulus changes only at falling edges.
	initial begin
		@(negedge clk_i);
		t_reset();
		t_soft();
		t_pwm();
		t_cs();
		t_ovp();
		t_burst();
		t_reduce();
		t_otp();
		give_verdict();
	end
endmodule : mfp_core_tb

// >>> test/mfp_sense_model.sv
// Behavioural model of the power switch and its current sense network.
module mfp_sense_model (
	input wire logic clk_i,
	input wire logic gate_i,
	input wire logic [9:0] soft_mv_i,
	input wire logic [15:0] fb_cyc_i,
	input wire logic [15:0] mv_step_i,
	output logic cs_fb_o,
	output logic cs_soft_o,
	output logic valley_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int on_q;
	int off_q;
	// Current ramps while the switch conducts; the drain rings when open.
	always_ff @(posedge clk_i) begin
		on_q <= gate_i ? on_q + 1 : 0;
		off_q <= gate_i ? 0 : off_q + 1;
	end
	// Comparators drop as soon as the switch opens, as the real sense does.
	assign cs_fb_o = gate_i && on_q >= int'(fb_cyc_i);
	assign cs_soft_o = gate_i && mv_step_i != 16'h0000
		&& on_q * int'(mv_step_i) >= int'(soft_mv_i);
	assign valley_o = !gate_i && off_q % 40 == 39;
endmodule : mfp_sense_model
